// ---- src/pmeirq_pkg.sv ----
// Purpose: Constants for the master error interrupt status block
// Assumes: 16-bit memory-mapped register port, 12-bit offsets
// Notes: Control and bridge-control offsets are placed locally
package pmeirq_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int NUM_SRC = 6;
  localparam int CMD_W = 4;
  localparam int FADDR_W = 32;

  // Register offsets
  localparam logic [11:0] OFS_STATUS = 12'h068;
  localparam logic [11:0] OFS_CONTROL = 12'h06C;
  localparam logic [11:0] OFS_BRIDGE_CTL = 12'h040;

  // Status layout
  localparam int ST_FLAG_LO = 0;
  localparam int ST_FLAG_HI = 5;
  localparam int ST_CMD_LO = 8;
  localparam int ST_CMD_HI = 11;

  // Source bit positions, shared by status flags and enables
  localparam int SRC_DET_PARITY = 0;
  localparam int SRC_RCV_PARITY = 1;
  localparam int SRC_SYS_ERR = 2;
  localparam int SRC_MST_ABORT = 3;
  localparam int SRC_TGT_ABORT = 4;
  localparam int SRC_RETRY_TO = 5;

  // Control layout
  localparam int CTL_EN_LO = 0;
  localparam int CTL_EN_HI = 5;
  localparam int CTL_DPER_SEL = 8;
  localparam int CTL_RPER_SEL = 9;
  localparam logic [15:0] CTL_WR_MASK = 16'h033F;

  // Bridge control layout
  localparam int BCTL_BUS_RESET = 0;

  // Reset values
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [31:0] FADDR_RST = 32'h00000000;

  // Bus command codes
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
endpackage

// ---- src/pmeirq_flag.sv ----
// Purpose: One sticky status flag, set by hardware, cleared by software
// Assumes: Set and clear are single-cycle strobes on core_clk
// Notes: Set wins over a simultaneous clear so no event is lost
`timescale 1ns/1ns
`default_nettype none
module pmeirq_flag (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic set_i,
  input wire logic clr_i,
  // State
  output var logic flag_r
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (set_i) begin
      flag_r <= 1'b1;
    end else if (clr_i) begin
      flag_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- src/pmeirq_top.sv ----
// Purpose: Master error status capture and interrupt routing
// Assumes: Error strobes and command/address are valid in one cycle
// Notes: Bus reset is started here but never touches these registers
// Function
// - Control register clears on system reset
// - Bus reset leaves control register untouched
// - Bus-reset bit write starts a bus reset
// - Flags set regardless of enable bits
// - NMI needs bridge and global NMI enables
// - Grant time-out shares the maskable request
// - Status bits 11..8 hold failing command
// - Command held until any set flag is cleared, then reads zero
// - Latched codes use standard bus encoding
// - Field reads zero when nothing latched
// - Unissued command codes are never latched
// - First error command kept, later ignored
// - No indication which flag owns command
// - Failing transaction address is captured
// - Writing one clears flag, zero keeps
// - Distinct flags for each error source
// - Enables gate; parity selects NMI or maskable
`timescale 1ns/1ns
`default_nettype none
module pmeirq_top
  import pmeirq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output var logic [DATA_W-1:0] reg_rdata_r,
  // Error events from the master controller
  input wire logic retry_timeout_evt,
  input wire logic target_abort_evt,
  input wire logic master_abort_evt,
  input wire logic system_error_evt,
  input wire logic received_parity_evt,
  input wire logic detected_parity_evt,
  input wire logic [CMD_W-1:0] err_cmd,
  input wire logic [FADDR_W-1:0] err_addr,
  // Enables and grant time-out request held in other registers
  input wire logic bridge_nmi_enable,
  input wire logic global_nmi_enable,
  input wire logic grant_timeout_irq,
  // Interrupt outputs
  output var logic bridge_irq_r,
  output var logic bridge_nmi_r,
  // Bus reset start and address capture
  output var logic bus_reset_start_r,
  output var logic [FADDR_W-1:0] failed_address_capture_r
);
  logic [NUM_SRC-1:0] evt;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] clr;
  logic [NUM_SRC-1:0] nmi_sel;
  logic [NUM_SRC-1:0] active;
  logic [DATA_W-1:0] control_r;
  logic [DATA_W-1:0] control_nxt;
  logic [CMD_W-1:0] failed_command_code_r;
  logic [CMD_W-1:0] failed_command_code_nxt;
  logic [FADDR_W-1:0] faddr_nxt;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] rd_mux;
  logic hit_status;
  logic hit_control;
  logic hit_bctl;
  logic wr_status;
  logic wr_control;
  logic any_evt;
  logic any_flag;
  logic any_clear;
  logic first_err;
  logic cmd_issued;
  logic irq_nxt;
  logic nmi_nxt;
  logic [NUM_SRC-1:0] enables;
  logic [NUM_SRC-1:0] mask_src;
  logic [NUM_SRC-1:0] nmi_src;
  logic [CMD_W-1:0] cmd_filtered;
  logic [DATA_W-1:0] control_view;
  logic nmi_gate;
  logic bus_reset_req;

  // Address decode
  assign hit_status = (reg_addr == OFS_STATUS);
  assign hit_control = (reg_addr == OFS_CONTROL);
  assign hit_bctl = (reg_addr == OFS_BRIDGE_CTL);
  assign wr_status = reg_wr && hit_status;
  assign wr_control = reg_wr && hit_control;

  // Event vector in status bit order
  assign evt[SRC_RETRY_TO] = retry_timeout_evt;
  assign evt[SRC_TGT_ABORT] = target_abort_evt;
  assign evt[SRC_MST_ABORT] = master_abort_evt;
  assign evt[SRC_SYS_ERR] = system_error_evt;
  assign evt[SRC_RCV_PARITY] = received_parity_evt;
  assign evt[SRC_DET_PARITY] = detected_parity_evt;

  // Only the two parity sources can be steered to NMI
  assign nmi_sel[SRC_DET_PARITY] = control_r[CTL_DPER_SEL];
  assign nmi_sel[SRC_RCV_PARITY] = control_r[CTL_RPER_SEL];
  assign nmi_sel[NUM_SRC-1:2] = '0;

  // One sticky flag per source, write-one-to-clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
      assign clr[gi] = wr_status && reg_wdata[ST_FLAG_LO + gi];
      pmeirq_flag u_flag (
        .core_clk(core_clk),
        .rst(rst),
        .set_i(evt[gi]),
        .clr_i(clr[gi]),
        .flag_r(flags[gi])
      );
    end
  endgenerate

  // Interrupt routing
  assign enables = control_r[CTL_EN_HI:CTL_EN_LO];
  assign active = flags & enables;
  assign mask_src = active & ~nmi_sel;
  assign nmi_src = active & nmi_sel;
  // Both NMI enables live outside; either one low drops the NMI
  assign nmi_gate = bridge_nmi_enable && global_nmi_enable;
  assign irq_nxt = (|mask_src) || grant_timeout_irq;
  assign nmi_nxt = (|nmi_src) && nmi_gate;

  // Command capture
  assign any_evt = |evt;
  assign any_flag = |flags;
  assign any_clear = |(clr & flags);
  assign first_err = any_evt && !any_flag;
  // Codes the master never issues are recorded as not latched
  assign cmd_issued = (err_cmd != CMD_SPECIAL)
                      && (err_cmd[3:2] != 2'b11);
  assign cmd_filtered = cmd_issued ? err_cmd : CMD_NONE;
  assign failed_command_code_nxt =
    first_err ? cmd_filtered :
    any_clear ? CMD_NONE :
    failed_command_code_r;
  assign faddr_nxt = first_err ? err_addr : failed_address_capture_r;

  // Control: only defined bits are writable, reserved read zero
  assign control_nxt = wr_control ? (reg_wdata & CTL_WR_MASK) : control_r;

  // Read view; the field carries no owner tag for pending flags
  assign status_view = {4'h0, failed_command_code_r, 2'b00, flags};
  // Masked again on read so reserved control bits never leak out
  assign control_view = control_r & CTL_WR_MASK;
  assign rd_mux = hit_status ? status_view :
                  hit_control ? control_view :
                  16'h0000;

  // System reset only; bus reset has no path into this register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      control_r <= CONTROL_RST;
    end else begin
      control_r <= control_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      failed_command_code_r <= CMD_NONE;
    end else begin
      failed_command_code_r <= failed_command_code_nxt;
    end
  end

  // Cleared only by reset; only the next first error reloads it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      failed_address_capture_r <= FADDR_RST;
    end else begin
      failed_address_capture_r <= faddr_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bridge_irq_r <= 1'b0;
    end else begin
      bridge_irq_r <= irq_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bridge_nmi_r <= 1'b0;
    end else begin
      bridge_nmi_r <= nmi_nxt;
    end
  end

  // Bus reset bit is self-clearing: a one-cycle start pulse
  assign bus_reset_req = reg_wr && hit_bctl
                         && reg_wdata[BCTL_BUS_RESET];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_reset_start_r <= 1'b0;
    end else begin
      bus_reset_start_r <= bus_reset_req;
    end
  end

  // Read data holds between reads to keep the port quiet
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/pmeirq_agent.sv ----
// Purpose: Bus agents raising master error events
// Assumes: Each event is one core_clk cycle wide
// Notes: Command and address do not hold once the event is gone
`timescale 1ns/1ns
`default_nettype none
module pmeirq_agent (
  // Clock
  input wire logic core_clk,
  // Error events, command and address
  output var logic [5:0] evt,
  output var logic [3:0] cmd,
  output var logic [31:0] addr
);
  initial {evt, cmd, addr} = '0;
  task automatic fire(input logic [5:0] e, input logic [3:0] c);
    @(posedge core_clk);
    #1 {evt, cmd, addr} = {e, c, 28'hABCDE12, c};
    @(posedge core_clk);
    // Inverted so a stale command differs from the one just driven
    #1 {evt, cmd, addr} = {6'h00, ~cmd, ~addr};
  endtask
endmodule
`default_nettype wire

// ---- testbench/pmeirq_asserts.sv ----
// Purpose: Port-level checks for the error status block
// Assumes: Single clock, async active-high reset
// Notes: Flags are internal, so status reads are checked
`timescale 1ns/1ns
`default_nettype none
module pmeirq_asserts
  import pmeirq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata_r,
  // Interrupts and bus reset
  input wire logic bridge_nmi_enable,
  input wire logic global_nmi_enable,
  input wire logic grant_timeout_irq,
  input wire logic bridge_irq_r,
  input wire logic bridge_nmi_r,
  input wire logic bus_reset_start_r
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  wire logic st_rd = reg_rd && reg_addr == OFS_STATUS;
  wire logic ct_wr = reg_wr && reg_addr == OFS_CONTROL;
  wire logic ct_rd = reg_rd && reg_addr == OFS_CONTROL;
  wire logic br_wr = reg_wr && reg_addr == OFS_BRIDGE_CTL && reg_wdata[0];
  chk_busrst_pulse:
    assert property (br_wr ##1 !br_wr |-> bus_reset_start_r ##1
      !bus_reset_start_r) else $error("bus reset pulse");
  chk_busrst_cause:
    assert property (bus_reset_start_r |-> $past(br_wr))
    else $error("bus reset without write");
  chk_grant_shared:
    assert property (grant_timeout_irq |=> bridge_irq_r)
    else $error("grant request lost");
  chk_nmi_gate:
    assert property (bridge_nmi_r |->
      $past(bridge_nmi_enable && global_nmi_enable)) else $error("nmi");
  chk_status_rsvd:
    assert property (st_rd |=> reg_rdata_r[15:12] == 4'h0 &&
      reg_rdata_r[7:6] == 2'h0) else $error("status reserved bits");
  chk_cmd_legal:
    assert property (st_rd |=> !(reg_rdata_r[11:8] inside
      {4'h1, [4'hC:4'hF]})) else $error("unissued code latched");
  chk_cmd_clear:
    assert property (st_rd |=> reg_rdata_r[5:0] != 6'h00 ||
      reg_rdata_r[11:8] == 4'h0) else $error("stale command");
  chk_ctl_write:
    assert property (ct_wr ##1 !reg_wr ##1 ct_rd |=>
      reg_rdata_r == ($past(reg_wdata, 3) & CTL_WR_MASK))
    else $error("control readback");
endmodule
bind pmeirq_top pmeirq_asserts u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata_r(reg_rdata_r),
  .bridge_nmi_enable(bridge_nmi_enable),
  .global_nmi_enable(global_nmi_enable),
  .grant_timeout_irq(grant_timeout_irq),
  .bridge_irq_r(bridge_irq_r),
  .bridge_nmi_r(bridge_nmi_r),
  .bus_reset_start_r(bus_reset_start_r)
);
`default_nettype wire

// ---- testbench/pci_master_error_irq_status_tb_top.sv ----
// Purpose: Self-checking bench for the error status block
// Assumes: Agent model raises the error events
// Notes: Status reads stand in for the internal flags
`timescale 1ns/1ns
`default_nettype none
module pci_master_error_irq_status_tb_top;
  import pmeirq_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic bne = 1'b0, gne = 1'b0, gto = 1'b0;
  logic irq, nmi, brs;
  logic [11:0] ad = 12'h000;
  logic [15:0] wd = 16'h0000, rdat;
  logic [5:0] evt;
  logic [3:0] cmd;
  logic [31:0] addr, fa;
  int error_cnt = 0, check_count = 0, cyc = 0;
  pmeirq_agent u_agent (.core_clk(core_clk), .evt(evt), .cmd(cmd),
    .addr(addr));
  pmeirq_top u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(ad),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata_r(rdat),
    .retry_timeout_evt(evt[5]), .target_abort_evt(evt[4]),
    .master_abort_evt(evt[3]), .system_error_evt(evt[2]),
    .received_parity_evt(evt[1]), .detected_parity_evt(evt[0]),
    .err_cmd(cmd), .err_addr(addr), .bridge_nmi_enable(bne),
    .global_nmi_enable(gne), .grant_timeout_irq(gto), .bridge_irq_r(irq),
    .bridge_nmi_r(nmi), .bus_reset_start_r(brs),
    .failed_address_capture_r(fa));
  initial forever #5 core_clk = ~core_clk;
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) if (++cyc == 2000) begin
    error_cnt++;
    finish_test;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write when w is 1, else read and compare with d
  task automatic acc(input logic w, input logic [11:0] a,
      input logic [15:0] d);
    @(posedge core_clk);
    #1 {wr, rd, ad, wd} = {w, !w, a, w ? d : 16'h0000};
    @(posedge core_clk);
    #1 {wr, rd} = 2'b00;
    if (!w) chk(rdat, d);
  endtask
  task automatic t_reset;
    acc(0, OFS_CONTROL, 16'h0000);
    acc(1, OFS_CONTROL, CTL_WR_MASK);
    acc(0, OFS_CONTROL, CTL_WR_MASK);
    acc(1, OFS_BRIDGE_CTL, 16'h0001);
    chk(brs, 1'b1);
    @(posedge core_clk);
    #1 chk(brs, 1'b0);
    acc(1, OFS_BRIDGE_CTL, 16'h0000);
    chk(brs, 1'b0);
    acc(0, OFS_BRIDGE_CTL, 16'h0000);
    acc(0, OFS_CONTROL, CTL_WR_MASK);
    rst = 1'b1;
    @(posedge core_clk);
    #1 rst = 1'b0;
    acc(0, OFS_CONTROL, 16'h0000);
  endtask
  task automatic t_flags;
    logic [3:0] code [6] = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD,
      CMD_MEM_WR, CMD_CFG_RD, CMD_CFG_WR};
    logic [5:0] m;
    for (int i = 0; i < 6; i++) begin
      m = 6'h01 << i;
      u_agent.fire(m, code[i]);
      acc(0, OFS_STATUS, {4'h0, code[i], 2'b00, m});
      chk(fa, {28'hABCDE12, code[i]});
      acc(1, OFS_STATUS, {10'h000, ~m});
      acc(0, OFS_STATUS, {4'h0, code[i], 2'b00, m});
      acc(1, OFS_STATUS, {10'h000, m});
      acc(0, OFS_STATUS, 16'h0000);
      chk(irq, 1'b0);
    end
  endtask
  task automatic t_first;
    u_agent.fire(6'h10, CMD_MEM_RD);
    u_agent.fire(6'h08, CMD_CFG_WR);
    acc(0, OFS_STATUS, 16'h0618);
    chk(fa, 32'hABCDE126);
    acc(1, OFS_STATUS, 16'h0010);
    acc(0, OFS_STATUS, 16'h0008);
    acc(1, OFS_STATUS, 16'h0008);
    u_agent.fire(6'h20, 4'hC);
    acc(0, OFS_STATUS, 16'h0020);
    acc(1, OFS_STATUS, 16'h0020);
  endtask
  task automatic t_irq;
    {bne, gne} = 2'b11;
    acc(1, OFS_CONTROL, 16'h0111);
    u_agent.fire(6'h11, CMD_IO_RD);
    @(posedge core_clk);
    #1 chk({irq, nmi}, 2'b11);
    gne = 1'b0;
    @(posedge core_clk);
    #1 chk(nmi, 1'b0);
    acc(1, OFS_STATUS, 16'h0011);
    @(posedge core_clk);
    #1 chk(irq, 1'b0);
    gto = 1'b1;
    @(posedge core_clk);
    #1 chk(irq, 1'b1);
    gto = 1'b0;
    // Received parity steered to NMI, then bridge enable dropped
    acc(1, OFS_CONTROL, 16'h0202);
    gne = 1'b1;
    u_agent.fire(6'h02, CMD_MEM_WR);
    @(posedge core_clk);
    #1 chk({irq, nmi}, 2'b01);
    bne = 1'b0;
    @(posedge core_clk);
    #1 chk(nmi, 1'b0);
    acc(1, OFS_STATUS, 16'h0002);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    t_reset;
    t_flags;
    t_first;
    t_irq;
    finish_test;
  end
endmodule
`default_nettype wire
